// ===== hw/fatm_pkg.sv
// Purpose: Shared constants and types of the fault and temperature alarm monitor
// Assumes: 8-bit register addresses, 24-bit register data, 1 MHz sample strobe
// Notes: Register offsets are the printed byte offsets of the register port
package fatm_pkg;

    // ==========================================================
    // Register port
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;

    localparam logic [7:0] ADDR_FAST_LEVEL = 8'h00;
    localparam logic [7:0] ADDR_PHASE = 8'h0C;
    localparam logic [7:0] ADDR_INT_TEMP = 8'h0E;
    localparam logic [7:0] ADDR_EXT_TEMP = 8'h0F;
    localparam logic [7:0] ADDR_FAST_CTL = 8'h10;
    localparam logic [7:0] ADDR_MODE = 8'h18;
    localparam logic [7:0] ADDR_TEMP_CTL = 8'h1B;
    localparam logic [7:0] ADDR_EXT_GAIN = 8'h1C;
    localparam logic [7:0] ADDR_EXT_OFS = 8'h1D;

    // ==========================================================
    // Reset values and the implemented mode bit mask
    localparam logic [15:0] FAST_CTL_RST = 16'hFFFF;
    localparam logic [15:0] TEMP_CTL_RST = 16'h07FF;
    localparam logic [15:0] MODE_RST = 16'h0000;
    localparam logic [15:0] MODE_IMPL_MASK = 16'h1200;
    localparam logic [7:0] EXT_CAL_RST = 8'h00;
    localparam logic [23:0] LEVEL_RST = 24'h000000;
    localparam logic [15:0] PHASE_RST = 16'h0000;
    localparam logic [9:0] TEMP_VAL_RST = 10'h000;

    // ==========================================================
    // Field positions
    localparam int FLC_CYCLE_BIT = 15;
    localparam int FLC_THR_MSB = 14;
    localparam int MODE_FREQ_BIT = 9;
    localparam int MODE_PIN_FUNC_BIT = 12;
    localparam int TC_MEAS_OFF_BIT = 15;
    localparam int TC_ALARM_SRC_BIT = 14;
    localparam int TC_SRC_MSB = 13;
    localparam int TC_SRC_LSB = 12;
    localparam int TC_IVL_MSB = 11;
    localparam int TC_IVL_LSB = 10;
    localparam int TC_THR_MSB = 9;
    localparam int LEVEL_CMP_MSB = 23;
    localparam int LEVEL_CMP_LSB = 9;

    // ==========================================================
    // Timing
    localparam int SAMPLE_RATE_HZ = 1000000;
    localparam int LINE_50_HZ = 50;
    localparam int LINE_60_HZ = 60;
    localparam int HALF_50_SAMPLES = SAMPLE_RATE_HZ / (2 * LINE_50_HZ);
    localparam int HALF_60_SAMPLES = SAMPLE_RATE_HZ / (2 * LINE_60_HZ);
    localparam int ZX_DELAY_US = 570;
    localparam int ZX_DELAY_SAMPLES = (ZX_DELAY_US * (SAMPLE_RATE_HZ / 1000)) / 1000;
    localparam int CLK_HZ = 20000000;
    localparam int TEMP_BASE_MS = 50;
    localparam int TEMP_BASE_CYCLES = (CLK_HZ / 1000) * TEMP_BASE_MS;

    // ==========================================================
    // Types
    typedef enum logic [1:0]
    {
        TSRC_AUTO0 = 2'b00,
        TSRC_AUTO1 = 2'b01,
        TSRC_INT = 2'b10,
        TSRC_EXT = 2'b11
    } fatm_tsrc_t;

    typedef enum logic [1:0]
    {
        TS_IDLE = 2'b00,
        TS_WAIT_INT = 2'b01,
        TS_WAIT_EXT = 2'b10
    } fatm_tstate_t;

endpackage

// ===== hw/fatm_zx_delay.sv
// Purpose: Delays a sampled level by a fixed number of sample strobes
// Assumes: sample_valid is a one-cycle strobe at the sample rate
// Notes: A change that reverts before the delay expires never reaches the output
`timescale 1ns/1ns
module fatm_zx_delay
#(
    parameter int DELAY = 570
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic sample_valid,
    input wire logic level_in,
    output logic level_out
);

    logic out_q;
    logic out_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    wire differs = level_in != out_q;
    wire expire = cnt_q == 16'(DELAY - 1);

    // ==========================================================
    // Delay counter
    always_comb
    begin
        out_d = out_q;
        cnt_d = cnt_q;
        if (sample_valid)
        begin
            if (!differs)
            begin
                cnt_d = 16'h0000;
            end
            else if (expire)
            begin
                out_d = level_in;
                cnt_d = 16'h0000;
            end
            else
            begin
                cnt_d = cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            out_q <= 1'b0;
            cnt_q <= 16'h0000;
        end
        else
        begin
            out_q <= out_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_out = out_q;

endmodule

// ===== hw/fatm_monitor.sv
// Purpose: Fast current level, leakage and temperature alarm, phase angle, zero cross, temperature control
// Assumes: Samples arrive with a one-cycle sample_valid strobe at 1 MHz; register port sits behind the serial link
// Notes: Register reads come from a flip-flop one cycle after the address is presented
`timescale 1ns/1ns
module fatm_monitor
    import fatm_pkg::*;
#(
    parameter int LEVEL_SHIFT = 14,
    parameter int HPF_SHIFT = 8,
    parameter int TEMP_INTERVAL_CYCLES = fatm_pkg::TEMP_BASE_CYCLES
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fatm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [fatm_pkg::DATA_W-1:0] reg_wr_data,
    output logic [fatm_pkg::DATA_W-1:0] reg_rd_data,
    input wire logic sample_valid,
    input wire logic signed [23:0] filtered_current_wave,
    input wire logic signed [23:0] voltage_wave,
    input wire logic hpf_enable,
    input wire logic energy_pulse_in,
    output logic temp_conv_req,
    output logic temp_conv_ext,
    input wire logic temp_int_done,
    input wire logic [9:0] temp_int_code,
    input wire logic temp_sense_done,
    input wire logic [9:0] temp_sense_code,
    output logic [7:0] external_sensor_gain,
    output logic [7:0] external_sensor_offset,
    output logic pulse_alarm_pin,
    output logic zero_cross_pin
);
    import fatm_pkg::*;

    // ==========================================================
    // Helpers
    function automatic logic [23:0] abs24(input logic signed [23:0] x);
        return x[23] ? 24'(-x) : 24'(x);
    endfunction

    function automatic logic [23:0] sat24(input logic [39:0] x);
        return (x[39:24] != 16'h0000) ? 24'hFFFFFF : x[23:0];
    endfunction

    function automatic logic [23:0] ivl_cycles(input logic [1:0] sel);
        return 24'(TEMP_INTERVAL_CYCLES) << sel;
    endfunction

    // ==========================================================
    // Register state
    logic [15:0] fast_level_control_q;
    logic [15:0] mode_q;
    logic [15:0] temperature_control_q;
    logic [7:0] ext_gain_q;
    logic [7:0] ext_ofs_q;
    logic [23:0] fast_current_level_q;
    logic [15:0] phase_angle_reg_q;
    logic [9:0] int_temp_q;
    logic [9:0] ext_temp_q;
    logic [23:0] rd_data_q;
    logic [23:0] rd_data_d;

    wire wr_fast_ctl = reg_wr_en && (reg_addr == ADDR_FAST_CTL);
    wire wr_mode = reg_wr_en && (reg_addr == ADDR_MODE);
    wire wr_temp_ctl = reg_wr_en && (reg_addr == ADDR_TEMP_CTL);
    wire wr_ext_gain = reg_wr_en && (reg_addr == ADDR_EXT_GAIN);
    wire wr_ext_ofs = reg_wr_en && (reg_addr == ADDR_EXT_OFS);

    wire full_cycle = fast_level_control_q[FLC_CYCLE_BIT];
    wire [14:0] leak_threshold = fast_level_control_q[FLC_THR_MSB:0];
    wire freq_60 = mode_q[MODE_FREQ_BIT];
    wire pin_alarm_mode = mode_q[MODE_PIN_FUNC_BIT];
    wire meas_off = temperature_control_q[TC_MEAS_OFF_BIT];
    wire leak_source = temperature_control_q[TC_ALARM_SRC_BIT];
    wire [1:0] temp_src = temperature_control_q[TC_SRC_MSB:TC_SRC_LSB];
    wire [1:0] temp_ivl = temperature_control_q[TC_IVL_MSB:TC_IVL_LSB];
    wire [9:0] temp_threshold = temperature_control_q[TC_THR_MSB:0];

    // Writes to read-only offsets are dropped; value registers change only from hardware
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            fast_level_control_q <= FAST_CTL_RST;
            mode_q <= MODE_RST;
            temperature_control_q <= TEMP_CTL_RST;
            ext_gain_q <= EXT_CAL_RST;
            ext_ofs_q <= EXT_CAL_RST;
        end
        else
        begin
            if (wr_fast_ctl)
            begin
                fast_level_control_q <= reg_wr_data[15:0];
            end
            if (wr_mode)
            begin
                mode_q <= reg_wr_data[15:0] & MODE_IMPL_MASK;
            end
            if (wr_temp_ctl)
            begin
                temperature_control_q <= reg_wr_data[15:0];
            end
            if (wr_ext_gain)
            begin
                ext_gain_q <= reg_wr_data[7:0];
            end
            if (wr_ext_ofs)
            begin
                ext_ofs_q <= reg_wr_data[7:0];
            end
        end
    end

    // ==========================================================
    // Read mux, narrow registers sit in the low bits
    always_comb
    begin
        case (reg_addr)
            ADDR_FAST_LEVEL: rd_data_d = fast_current_level_q;
            ADDR_PHASE: rd_data_d = {8'h00, phase_angle_reg_q};
            ADDR_INT_TEMP: rd_data_d = {14'h0000, int_temp_q};
            ADDR_EXT_TEMP: rd_data_d = {14'h0000, ext_temp_q};
            ADDR_FAST_CTL: rd_data_d = {8'h00, fast_level_control_q};
            ADDR_MODE: rd_data_d = {8'h00, mode_q};
            ADDR_TEMP_CTL: rd_data_d = {8'h00, temperature_control_q};
            ADDR_EXT_GAIN: rd_data_d = {16'h0000, ext_gain_q};
            ADDR_EXT_OFS: rd_data_d = {16'h0000, ext_ofs_q};
            default: rd_data_d = 24'h000000;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            rd_data_q <= 24'h000000;
        end
        else
        begin
            rd_data_q <= rd_data_d;
        end
    end

    assign reg_rd_data = rd_data_q;
    assign external_sensor_gain = ext_gain_q;
    assign external_sensor_offset = ext_ofs_q;

    // ==========================================================
    // Optional high-pass: subtract a slow running mean
    logic signed [23:0] dc_q;
    wire signed [23:0] hp_wave = 24'(filtered_current_wave - dc_q);
    wire signed [23:0] dc_step = hp_wave >>> HPF_SHIFT;
    wire signed [23:0] level_wave = hpf_enable ? hp_wave : filtered_current_wave;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            dc_q <= 24'sh000000;
        end
        else if (sample_valid)
        begin
            dc_q <= 24'(dc_q + dc_step);
        end
    end

    // ==========================================================
    // Fast level accumulation and leakage compare
    logic [39:0] acc_q;
    logic [14:0] win_cnt_q;
    logic leak_alarm_q;
    // Window length follows the line frequency; full cycle doubles it
    wire [14:0] half_len = freq_60 ? 15'(HALF_60_SAMPLES) : 15'(HALF_50_SAMPLES);
    wire [14:0] win_len = full_cycle ? 15'(half_len << 1) : half_len;
    wire [39:0] acc_next = acc_q + {16'h0000, abs24(level_wave)};
    wire refresh = sample_valid && (win_cnt_q == 15'(win_len - 15'h0001));
    wire [23:0] level_new = sat24(acc_next >> LEVEL_SHIFT);
    wire leak_hit = level_new[LEVEL_CMP_MSB:LEVEL_CMP_LSB] >= leak_threshold;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            acc_q <= 40'h0000000000;
            win_cnt_q <= 15'h0000;
            fast_current_level_q <= LEVEL_RST;
            leak_alarm_q <= 1'b0;
        end
        else if (refresh)
        begin
            acc_q <= 40'h0000000000;
            win_cnt_q <= 15'h0000;
            fast_current_level_q <= level_new;
            leak_alarm_q <= leak_hit;
        end
        else if (sample_valid)
        begin
            acc_q <= acc_next;
            win_cnt_q <= 15'(win_cnt_q + 15'h0001);
        end
    end

    // ==========================================================
    // Phase angle between positive zero crossings
    logic v_pos_q;
    logic i_pos_q;
    logic [15:0] ph_cnt_q;
    wire v_rise = sample_valid && !v_pos_q && !voltage_wave[23];
    wire i_rise = sample_valid && !i_pos_q && !filtered_current_wave[23];
    // Count saturates so a missing voltage crossing does not wrap to a small angle
    wire [15:0] ph_cnt_inc = (ph_cnt_q == 16'hFFFF) ? ph_cnt_q : 16'(ph_cnt_q + 16'h0001);

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            v_pos_q <= 1'b0;
            i_pos_q <= 1'b0;
            ph_cnt_q <= 16'h0000;
            phase_angle_reg_q <= PHASE_RST;
        end
        else if (sample_valid)
        begin
            v_pos_q <= !voltage_wave[23];
            i_pos_q <= !filtered_current_wave[23];
            ph_cnt_q <= v_rise ? 16'h0000 : ph_cnt_inc;
            if (i_rise)
            begin
                phase_angle_reg_q <= v_rise ? 16'h0000 : ph_cnt_inc;
            end
        end
    end

    // ==========================================================
    // Zero-cross output: high in the negative half, delayed
    fatm_zx_delay
    #(
        .DELAY(ZX_DELAY_SAMPLES)
    )
    u_zx
    (
        .core_clk(core_clk),
        .reset(reset),
        .sample_valid(sample_valid),
        .level_in(voltage_wave[23]),
        .level_out(zero_cross_pin)
    );

    // ==========================================================
    // Temperature measurement sequencing
    fatm_tstate_t tstate_q;
    fatm_tstate_t tstate_d;
    logic [23:0] ivl_cnt_q;
    logic auto_ext_q;
    logic conv_req_q;
    logic conv_ext_q;
    wire ivl_tick = ivl_cnt_q >= 24'(ivl_cycles(temp_ivl) - 24'h000001);
    wire auto_src = (temp_src == TSRC_AUTO0) || (temp_src == TSRC_AUTO1);
    // Automatic mode alternates internal and external conversions
    wire pick_ext = auto_src ? auto_ext_q : (temp_src == TSRC_EXT);
    wire start_conv = (tstate_q == TS_IDLE) && ivl_tick && !meas_off;

    always_comb
    begin
        tstate_d = tstate_q;
        case (tstate_q)
            TS_IDLE:
            begin
                if (start_conv)
                begin
                    tstate_d = pick_ext ? TS_WAIT_EXT : TS_WAIT_INT;
                end
            end
            TS_WAIT_INT:
            begin
                if (meas_off || temp_int_done)
                begin
                    tstate_d = TS_IDLE;
                end
            end
            TS_WAIT_EXT:
            begin
                if (meas_off || temp_sense_done)
                begin
                    tstate_d = TS_IDLE;
                end
            end
            default: tstate_d = TS_IDLE;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            tstate_q <= TS_IDLE;
            ivl_cnt_q <= 24'h000000;
            auto_ext_q <= 1'b0;
            conv_req_q <= 1'b0;
            conv_ext_q <= 1'b0;
        end
        else
        begin
            tstate_q <= meas_off ? TS_IDLE : tstate_d;
            ivl_cnt_q <= (meas_off || ivl_tick) ? 24'h000000 : 24'(ivl_cnt_q + 24'h000001);
            conv_req_q <= start_conv;
            if (start_conv)
            begin
                conv_ext_q <= pick_ext;
                auto_ext_q <= auto_src ? !auto_ext_q : auto_ext_q;
            end
        end
    end

    assign temp_conv_req = conv_req_q;
    assign temp_conv_ext = conv_ext_q;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            int_temp_q <= TEMP_VAL_RST;
            ext_temp_q <= TEMP_VAL_RST;
        end
        else
        begin
            if ((tstate_q == TS_WAIT_INT) && temp_int_done && !meas_off)
            begin
                int_temp_q <= temp_int_code;
            end
            if ((tstate_q == TS_WAIT_EXT) && temp_sense_done && !meas_off)
            begin
                ext_temp_q <= temp_sense_code;
            end
        end
    end

    // ==========================================================
    // Shared pulse/alarm pin
    logic pin_q;
    wire temp_alarm = ext_temp_q >= temp_threshold;
    wire alarm_sel = leak_source ? leak_alarm_q : temp_alarm;
    wire pin_d = pin_alarm_mode ? alarm_sel : energy_pulse_in;

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            pin_q <= 1'b0;
        end
        else
        begin
            pin_q <= pin_d;
        end
    end

    assign pulse_alarm_pin = pin_q;

endmodule

// ===== tb/fatm_monitor_assertions.sv
// Purpose: Port-level checks of the fault and temperature alarm monitor
// Assumes: Mode and temperature control writes are visible at the register port
// Notes: Shadow copies of two control registers stand in for state the ports do not show
`timescale 1ns/1ns
module fatm_checker
#(
    parameter int TEMP_INTERVAL_CYCLES = 50
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [fatm_pkg::ADDR_W-1:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [fatm_pkg::DATA_W-1:0] reg_wr_data,
    input wire logic [fatm_pkg::DATA_W-1:0] reg_rd_data,
    input wire logic energy_pulse_in,
    input wire logic temp_conv_req,
    input wire logic temp_conv_ext,
    input wire logic [7:0] external_sensor_gain,
    input wire logic pulse_alarm_pin
);
    import fatm_pkg::*;
    // ==========
    // Shadows
    logic [15:0] mode_q;
    logic [15:0] tc_q;
    logic [15:0] gap_q;
    wire wr_mode = reg_wr_en && reg_addr == ADDR_MODE;
    wire wr_tc = reg_wr_en && reg_addr == ADDR_TEMP_CTL;
    wire mapped = reg_addr inside {8'h00, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h18, 8'h1B, 8'h1C, 8'h1D};
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            mode_q <= MODE_RST;
            tc_q <= TEMP_CTL_RST;
            gap_q <= 16'hFFFF;
        end
        else
        begin
            if (wr_mode) mode_q <= reg_wr_data[15:0] & MODE_IMPL_MASK;
            if (wr_tc) tc_q <= reg_wr_data[15:0];
            if (temp_conv_req) gap_q <= 16'h0000;
            else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
        end
    end
    // ==========
    // Properties
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    a_pulse_pass: assert property (!$past(mode_q[12]) |-> pulse_alarm_pin == $past(energy_pulse_in))
        else $error("pin does not follow energy pulse");
    a_unmapped_zero: assert property (!$past(mapped) |-> reg_rd_data == 24'h000000)
        else $error("unmapped read not zero");
    a_mode_read: assert property ($past(reg_addr) == ADDR_MODE |-> reg_rd_data == {8'h00, $past(mode_q)})
        else $error("mode readback wrong");
    a_tctl_read: assert property ($past(reg_addr) == ADDR_TEMP_CTL |-> reg_rd_data == {8'h00, $past(tc_q)})
        else $error("temperature control readback wrong");
    a_gain_write: assert property (reg_wr_en && reg_addr == ADDR_EXT_GAIN
        |=> external_sensor_gain == $past(reg_wr_data[7:0]))
        else $error("gain port not updated");
    a_meas_off: assert property (tc_q[15] [*3] |-> !temp_conv_req)
        else $error("conversion while measurement off");
    a_conv_source: assert property (temp_conv_req && tc_q[13] && $stable(tc_q) && tc_q == $past(tc_q, 2)
        |-> temp_conv_ext == tc_q[12])
        else $error("conversion source wrong");
    a_req_pulse: assert property (temp_conv_req |=> !temp_conv_req)
        else $error("conversion request too long");
    a_req_gap: assert property (temp_conv_req |-> gap_q >= 16'(TEMP_INTERVAL_CYCLES - 1))
        else $error("conversion requests too close");
endmodule

bind fatm_monitor fatm_checker #(.TEMP_INTERVAL_CYCLES(TEMP_INTERVAL_CYCLES)) fatm_checker_inst
(
    .core_clk(core_clk),
    .reset(reset),
    .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data),
    .energy_pulse_in(energy_pulse_in),
    .temp_conv_req(temp_conv_req),
    .temp_conv_ext(temp_conv_ext),
    .external_sensor_gain(external_sensor_gain),
    .pulse_alarm_pin(pulse_alarm_pin)
);

// ===== tb/fatm_conv_model.sv
// Purpose: Temperature converter front end answering conversion requests
// Assumes: One conversion in flight at a time
// Notes: Answers alternate between prompt and slow; codes read inverted outside the done pulse
`timescale 1ns/1ns
module fatm_conv_model
#(
    parameter logic [9:0] INT_CODE = 10'h123,
    parameter logic [9:0] EXT_CODE = 10'h200
)
(
    input wire logic core_clk,
    input wire logic reset,
    input wire logic temp_conv_req,
    input wire logic temp_conv_ext,
    output logic temp_int_done,
    output logic [9:0] temp_int_code,
    output logic temp_sense_done,
    output logic [9:0] temp_sense_code
);
    int wait_q;
    logic ext_q;
    logic slow_q;
    wire done = wait_q == 1;
    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            wait_q <= 0;
            ext_q <= 1'b0;
            slow_q <= 1'b0;
        end
        else if (temp_conv_req)
        begin
            wait_q <= slow_q ? 30 : 1;
            slow_q <= !slow_q;
            ext_q <= temp_conv_ext;
        end
        else if (wait_q > 0)
            wait_q <= wait_q - 1;
    end
    assign temp_int_done = done && !ext_q;
    assign temp_sense_done = done && ext_q;
    assign temp_int_code = temp_int_done ? INT_CODE : ~INT_CODE;
    assign temp_sense_code = temp_sense_done ? EXT_CODE : ~EXT_CODE;
endmodule

// ===== tb/tb.sv
// Purpose: Register-level test of the fault and temperature alarm monitor
// Assumes: Samples every second clock so a 60 Hz half cycle fits the run
// Notes: Square current and voltage waves keep the magnitude constant
`timescale 1ns/1ns
module tb;
    import fatm_pkg::*;
    localparam int TIC = 50;
    localparam logic signed [23:0] AMP = 24'sh010000;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic reg_wr_en = 1'b0;
    logic sample_valid = 1'b0;
    logic energy_pulse_in = 1'b0;
    logic run = 1'b0;
    logic hpf_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [23:0] reg_wr_data = 24'h000000;
    logic [23:0] reg_rd_data;
    logic signed [23:0] cur_w = 24'sh0;
    logic signed [23:0] volt_w = 24'sh0;
    logic conv_req, conv_ext, int_done, sense_done, pin, zx;
    logic [9:0] int_code, sense_code;
    logic [7:0] gain, ofs;
    int n = 0;
    int fail_count = 0;
    int checked = 0;
    logic [7:0] ra [10] = '{8'h00, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h18, 8'h1B, 8'h1C, 8'h1D, 8'h05};
    logic [23:0] rv [10] = '{24'h0, 24'h0, 24'h0, 24'h0, 24'hFFFF, 24'h0, 24'h7FF, 24'h0, 24'h0, 24'h0};
    int zn [4] = '{500, 600, 1500, 1600};
    logic [23:0] zv [4] = '{24'h0, 24'h1, 24'h1, 24'h0};

    fatm_monitor #(.TEMP_INTERVAL_CYCLES(TIC)) fatm_monitor_inst
    (
        .core_clk(core_clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data),
        .sample_valid(sample_valid),
        .filtered_current_wave(cur_w),
        .voltage_wave(volt_w),
        .hpf_enable(hpf_en),
        .energy_pulse_in(energy_pulse_in),
        .temp_conv_req(conv_req),
        .temp_conv_ext(conv_ext),
        .temp_int_done(int_done),
        .temp_int_code(int_code),
        .temp_sense_done(sense_done),
        .temp_sense_code(sense_code),
        .external_sensor_gain(gain),
        .external_sensor_offset(ofs),
        .pulse_alarm_pin(pin),
        .zero_cross_pin(zx)
    );

    fatm_conv_model fatm_conv_model_inst
    (
        .core_clk(core_clk),
        .reset(reset),
        .temp_conv_req(conv_req),
        .temp_conv_ext(conv_ext),
        .temp_int_done(int_done),
        .temp_int_code(int_code),
        .temp_sense_done(sense_done),
        .temp_sense_code(sense_code)
    );

    // ==========
    // Clock and samples
    initial
    begin
        forever #25 core_clk = ~core_clk;
    end

    function automatic logic signed [23:0] sq(input int k);
        return ((k / 1000) % 2 == 1) ? AMP : -AMP;
    endfunction

    // Current lags voltage by 100 samples
    always @(posedge core_clk)
    begin
        #1;
        sample_valid = run && !sample_valid;
        if (sample_valid)
        begin
            volt_w = sq(n);
            cur_w = sq(n + 1900);
            n++;
        end
    end

    // ==========
    // Tasks
    task automatic print_verdict();
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge core_clk);
        #1;
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [23:0] e);
        reg_addr = a;
        @(posedge core_clk);
        #1;
        chk(reg_rd_data, e);
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic wait_n(input int t);
        for (int i = 0; i < 40000 && n < t; i++) step(1);
        if (n < t)
        begin
            fail_count++;
            print_verdict();
        end
    endtask

    // ==========
    // Sequence
    initial
    begin
        repeat (8) @(posedge core_clk);
        #1;
        reset = 1'b0;
        for (int i = 0; i < 10; i++) rd(ra[i], rv[i]);
        wr(8'h1C, 24'h0000A5);
        rd(8'h1C, 24'h0000A5);
        chk({16'h0000, gain}, 24'h0000A5);
        wr(8'h1D, 24'h00005A);
        rd(8'h1D, 24'h00005A);
        chk({16'h0000, ofs}, 24'h00005A);
        wr(8'h00, 24'h123456);
        rd(8'h00, 24'h000000);
        wr(8'h18, 24'hFFFFFF);
        rd(8'h18, 24'h001200);
        wr(8'h10, 24'hAB0041);
        rd(8'h10, 24'h000041);
        wr(8'h1B, 24'h0047FF);
        rd(8'h1B, 24'h0047FF);
        run = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            wait_n(zn[i]);
            chk(24'(zx), zv[i]);
        end
        wait_n(2500);
        rd(8'h0C, 24'h000064);
        wait_n(8340);
        rd(8'h00, 24'h008234);
        chk(24'(pin), 24'h000001);
        rd(8'h0E, 24'h000123);
        rd(8'h0F, 24'h000200);
        wr(8'h10, 24'h000042);
        wait_n(16672);
        rd(8'h00, 24'h008234);
        chk(24'(pin), 24'h000000);
        // High-pass lets each flat top decay, so the level roughly halves
        hpf_en = 1'b1;
        wait_n(25005);
        reg_addr = 8'h00;
        step(1);
        chk(24'(reg_rd_data > 24'h002000 && reg_rd_data < 24'h006000), 24'h000001);
        run = 1'b0;
        wr(8'h1B, 24'h003155);
        step(200);
        chk(24'(pin), 24'h000001);
        rd(8'h0F, 24'h000200);
        wr(8'h1B, 24'h003201);
        step(4);
        chk(24'(pin), 24'h000000);
        wr(8'h1B, 24'h00B201);
        step(300);
        wr(8'h18, 24'h000000);
        energy_pulse_in = 1'b1;
        step(2);
        chk(24'(pin), 24'h000001);
        energy_pulse_in = 1'b0;
        step(2);
        chk(24'(pin), 24'h000000);
        print_verdict();
    end
endmodule
